// ==== hw/scg_params.svh ====
// Constants of the system clock generator: addresses, fields, reset values, timing.
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// Serial control bus addresses
`define SCG_ADDR_RESET      8'h01
`define SCG_ADDR_SC1_PLL    8'hab
`define SCG_ADDR_SC1_REF    8'hac
`define SCG_ADDR_SC2_PLL    8'had
`define SCG_ADDR_SC2_REF    8'hae
`define SCG_ADDR_MAIN_PLL   8'hbc
`define SCG_ADDR_MAIN_REF   8'hbd

// Frame lengths in serial bits
`define SCG_ADDR_BITS       5'h08
`define SCG_DATA_BITS       5'h10

// PLL configure fields
`define SCG_PLL_N_MSB       11
`define SCG_PLL_N_LSB       0
`define SCG_PLL_V_MSB       15
`define SCG_PLL_V_LSB       12

// Reference configure fields
`define SCG_REF_R_MSB       11
`define SCG_REF_R_LSB       0
`define SCG_REF_PS_BIT      12
`define SCG_REF_EN_BIT      13
`define SCG_REF_ROUTE_MSB   15
`define SCG_REF_ROUTE_LSB   14

// Routing codes
`define SCG_ROUTE_PLL       2'h0
`define SCG_ROUTE_REF       2'h1

// Reset values, set for a 6.144 MHz reference and 96 kHz comparison
`define SCG_SC_PLL_RST      16'h0040
`define SCG_SC_REF_RST      16'h4040
`define SCG_SC_REF_EN_RST   16'h2000
`define SCG_MAIN_PLL_RST    16'h1100
`define SCG_MAIN_REF_RST    16'h0040

// Clock rates and times
`define SCG_CLK_KHZ         200000
`define SCG_XTAL_KHZ        6144
`define SCG_MAIN_KHZ        24576
`define SCG_GP_PERIOD_NS    250000
`define SCG_CONV_DIV        768
`define SCG_DPLL_GAIN       20

// Pin synchroniser bit positions and idle levels
`define SCG_PIN_DATA        0
`define SCG_PIN_SCLK        1
`define SCG_PIN_CSN         2
`define SCG_PIN_OSC         3
`define SCG_PIN_EXT         4
`define SCG_PIN_RST         5'h04

`endif

// ==== hw/scg_pkg.sv ====
// Types of the system clock generator.
package scg_pkg;

  typedef enum logic [1:0] {
    SCG_CB_ADDR,
    SCG_CB_DATA,
    SCG_CB_SKIP
  } scg_cbus_state_e;

  typedef logic [15:0] scg_word_t;
  typedef logic [1:0]  scg_route_t;

endpackage : scg_pkg

// ==== hw/scg_dpll.sv ====
// Digital PLL: reference divider, frequency-locked NCO and output divider.
`timescale 1ns/1ps
`default_nettype none

module scg_dpll
  import scg_pkg::*;
#(
  parameter int W    = 32,
  parameter int NW   = 12,
  parameter int VW   = 4,
  parameter int GAIN = 20
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Reference and settings
  input  wire logic          ref_tick,
  input  wire logic [NW-1:0] r_div,
  input  wire logic [NW-1:0] n_mul,
  input  wire logic [VW-1:0] v_div,
  // Loop outputs
  output logic               vco_tick,
  output logic               out_lvl
);

  logic [NW-1:0]      rcnt_q, rcnt_d, vcnt_q, vcnt_d, r_eff;
  logic [W-1:0]       acc_q, acc_d, inc_q, inc_d;
  logic [VW-1:0]      dcnt_q, dcnt_d, v_eff;
  logic               tick_q, tick_d, lvl_q, lvl_d, cmp, carry;
  logic signed [NW:0]  err;
  logic signed [W+1:0] adj, nxt;

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    r_eff  = (r_div == '0) ? NW'(1) : r_div;
    v_eff  = (v_div == '0) ? VW'(1) : v_div;
    {carry, acc_d} = {1'b0, acc_q} + {1'b0, inc_q};
    cmp    = ref_tick && (rcnt_q >= r_eff - NW'(1));
    rcnt_d = ref_tick ? (cmp ? '0 : rcnt_q + NW'(1)) : rcnt_q;
    // Loop error: wanted VCO ticks per comparison period minus counted ticks
    err    = $signed({1'b0, n_mul}) - $signed({1'b0, vcnt_q});
    adj    = $signed({{(W+1-NW){err[NW]}}, err}) <<< GAIN;
    nxt    = $signed({2'b00, inc_q}) + adj;
    inc_d  = inc_q;
    vcnt_d = vcnt_q;
    if (cmp) begin
      vcnt_d = NW'(carry);
      // Clamp keeps the NCO below half the system clock
      if (nxt < 0) begin
        inc_d = '0;
      end else if (nxt[W+1:W-1] != 3'h0) begin
        inc_d = {1'b0, {(W-1){1'b1}}};
      end else begin
        inc_d = nxt[W-1:0];
      end
    end else if (carry && (vcnt_q != {NW{1'b1}})) begin
      vcnt_d = vcnt_q + NW'(1);
    end
    tick_d = carry;
    dcnt_d = dcnt_q;
    lvl_d  = lvl_q;
    if (carry) begin
      if (dcnt_q >= v_eff - VW'(1)) begin
        dcnt_d = '0;
        lvl_d  = ~lvl_q;
      end else begin
        dcnt_d = dcnt_q + VW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= '0;
      vcnt_q <= '0;
      acc_q  <= '0;
      inc_q  <= '0;
      dcnt_q <= '0;
      tick_q <= 1'b0;
      lvl_q  <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      vcnt_q <= vcnt_d;
      acc_q  <= acc_d;
      inc_q  <= inc_d;
      dcnt_q <= dcnt_d;
      tick_q <= tick_d;
      lvl_q  <= lvl_d;
    end
  end

  assign vco_tick = tick_q;
  assign out_lvl  = lvl_q;

endmodule // scg_dpll

`default_nettype wire

// ==== hw/scg_top.sv ====
// System clock generator: reference, main clock, derived ticks, two system clocks.
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"

module scg_top
  import scg_pkg::*;
#(
  parameter int        XTAL_KHZ = `SCG_XTAL_KHZ,
  parameter bit        REDUCED  = 1'b0,
  parameter int        CONV_DIV = `SCG_CONV_DIV,
  parameter scg_word_t GP_DIV   = 16'(64'(`SCG_GP_PERIOD_NS) * 64'(`SCG_MAIN_KHZ) / 64'd1000000)
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      nrst,
  // Reference pins
  input  wire logic      osc_in,
  input  wire logic      ref_ext_select,
  // Serial control bus
  input  wire logic      cbus_sclk,
  input  wire logic      cbus_csn_n,
  input  wire logic      cbus_cmd_data,
  // Firmware side
  input  wire logic      idle_mode,
  input  wire logic      clock_param_load,
  input  wire scg_word_t clock_param_main_pll,
  input  wire scg_word_t clock_param_main_ref,
  input  wire scg_word_t clock_param_gp_div,
  // Clock outputs
  output logic           system_clock_output_one,
  output logic           system_clock_output_two,
  output logic           main_clock_out,
  output logic           general_purpose_timer_tick,
  output logic           converter_tick
);

  localparam logic [31:0] XTAL_INC   = 32'((64'(XTAL_KHZ) << 32) / 64'(`SCG_CLK_KHZ));
  localparam scg_word_t   SC_REF_RST = `SCG_SC_REF_RST | (REDUCED ? 16'h0000 : `SCG_SC_REF_EN_RST);

  // Write decode used by the frame decoder; the register apply path decodes paddr_q on its own
  function automatic logic is_reg_addr(input logic [7:0] a);
    is_reg_addr = (a == `SCG_ADDR_SC1_PLL) || (a == `SCG_ADDR_SC1_REF) ||
                  (a == `SCG_ADDR_SC2_PLL) || (a == `SCG_ADDR_SC2_REF) ||
                  (a == `SCG_ADDR_MAIN_PLL) || (a == `SCG_ADDR_MAIN_REF);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages two and three agree

  logic [4:0] pin_in, s1_q, s2_q, s3_q, filt_q, filt_d;

  assign pin_in = {ref_ext_select, osc_in, cbus_csn_n, cbus_sclk, cbus_cmd_data};

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < 5; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q   <= `SCG_PIN_RST;
      s2_q   <= `SCG_PIN_RST;
      s3_q   <= `SCG_PIN_RST;
      filt_q <= `SCG_PIN_RST;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference: crystal NCO or external clock on the oscillator pin

  logic [31:0] xacc_q, xacc_d;
  logic        ref_lvl_q, ref_lvl_d, ref_tick_q, ref_tick_d;

  always_comb begin
    xacc_d     = xacc_q + XTAL_INC;
    ref_lvl_d  = filt_q[`SCG_PIN_EXT] ? filt_q[`SCG_PIN_OSC] : xacc_q[31];
    ref_tick_d = ref_lvl_d && !ref_lvl_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xacc_q     <= '0;
      ref_lvl_q  <= 1'b0;
      ref_tick_q <= 1'b0;
    end else begin
      xacc_q     <= xacc_d;
      ref_lvl_q  <= ref_lvl_d;
      ref_tick_q <= ref_tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial bus frame decoder: address byte, then 16 data bits for clock registers

  scg_cbus_state_e cb_q, cb_d;
  logic [4:0]      bcnt_q, bcnt_d;
  logic [7:0]      addr_q, addr_d;
  scg_word_t       sh_q, sh_d;
  logic            wr_vld, sclk_rise, gp_tick_q;
  logic            pend_q, pend_d;
  logic [7:0]      paddr_q, paddr_d;
  scg_word_t       pdata_q, pdata_d;

  assign sclk_rise = s2_q[`SCG_PIN_SCLK] && s3_q[`SCG_PIN_SCLK] && !filt_q[`SCG_PIN_SCLK];

  always_comb begin
    cb_d   = cb_q;
    bcnt_d = bcnt_q;
    addr_d = addr_q;
    sh_d   = sh_q;
    wr_vld = 1'b0;
    if (filt_q[`SCG_PIN_CSN]) begin
      // Deselect drops any partial frame
      cb_d   = SCG_CB_ADDR;
      bcnt_d = '0;
    end else if (sclk_rise) begin
      case (cb_q)
        SCG_CB_ADDR: begin
          addr_d = {addr_q[6:0], s3_q[`SCG_PIN_DATA]};
          bcnt_d = bcnt_q + 5'h01;
          if (bcnt_d == `SCG_ADDR_BITS) begin
            bcnt_d = '0;
            if (addr_d == `SCG_ADDR_RESET) begin
              wr_vld = 1'b1;
              cb_d   = SCG_CB_SKIP;
            end else if (is_reg_addr(addr_d)) begin
              cb_d = SCG_CB_DATA;
            end else begin
              cb_d = SCG_CB_SKIP;
            end
          end
        end
        SCG_CB_DATA: begin
          sh_d   = {sh_q[14:0], s3_q[`SCG_PIN_DATA]};
          bcnt_d = bcnt_q + 5'h01;
          if (bcnt_d == `SCG_DATA_BITS) begin
            wr_vld = 1'b1;
            cb_d   = SCG_CB_SKIP;
          end
        end
        SCG_CB_SKIP: begin
          cb_d = SCG_CB_SKIP;
        end
        default: begin
          cb_d = SCG_CB_ADDR;
        end
      endcase
    end
  end

  // One pending write; in idle it waits for the timer tick, a newer write replaces it
  logic apply;

  always_comb begin
    apply   = pend_q && (!idle_mode || gp_tick_q);
    pend_d  = pend_q && !apply;
    paddr_d = paddr_q;
    pdata_d = pdata_q;
    if (wr_vld) begin
      pend_d  = 1'b1;
      paddr_d = addr_d;
      pdata_d = sh_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cb_q    <= SCG_CB_ADDR;
      bcnt_q  <= '0;
      addr_q  <= '0;
      sh_q    <= '0;
      pend_q  <= 1'b0;
      paddr_q <= '0;
      pdata_q <= '0;
    end else begin
      cb_q    <= cb_d;
      bcnt_q  <= bcnt_d;
      addr_q  <= addr_d;
      sh_q    <= sh_d;
      pend_q  <= pend_d;
      paddr_q <= paddr_d;
      pdata_q <= pdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write-only clock registers; nothing here is ever driven back onto the bus

  scg_word_t sc_pll_q [2];
  scg_word_t sc_pll_d [2];
  scg_word_t sc_ref_q [2];
  scg_word_t sc_ref_d [2];
  scg_word_t main_pll_q, main_pll_d, main_ref_q, main_ref_d, gp_div_q, gp_div_d;

  always_comb begin
    sc_pll_d   = sc_pll_q;
    sc_ref_d   = sc_ref_q;
    main_pll_d = main_pll_q;
    main_ref_d = main_ref_q;
    gp_div_d   = gp_div_q;
    if (clock_param_load) begin
      main_pll_d = clock_param_main_pll;
      main_ref_d = clock_param_main_ref;
      gp_div_d   = clock_param_gp_div;
    end
    if (apply) begin
      case (paddr_q)
        `SCG_ADDR_RESET: begin
          sc_pll_d = '{`SCG_SC_PLL_RST, `SCG_SC_PLL_RST};
          sc_ref_d = '{SC_REF_RST, SC_REF_RST};
        end
        `SCG_ADDR_SC1_PLL:  sc_pll_d[0] = pdata_q;
        `SCG_ADDR_SC2_PLL:  sc_pll_d[1] = pdata_q;
        `SCG_ADDR_SC1_REF:  sc_ref_d[0] = pdata_q;
        `SCG_ADDR_SC2_REF:  sc_ref_d[1] = pdata_q;
        // Firmware owns these; a bus write is still honoured so firmware can load them
        `SCG_ADDR_MAIN_PLL: main_pll_d = pdata_q;
        `SCG_ADDR_MAIN_REF: main_ref_d = pdata_q;
        default: begin
          sc_pll_d = sc_pll_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sc_pll_q   <= '{`SCG_SC_PLL_RST, `SCG_SC_PLL_RST};
      sc_ref_q   <= '{SC_REF_RST, SC_REF_RST};
      main_pll_q <= `SCG_MAIN_PLL_RST;
      main_ref_q <= `SCG_MAIN_REF_RST;
      gp_div_q   <= GP_DIV;
    end else begin
      sc_pll_q   <= sc_pll_d;
      sc_ref_q   <= sc_ref_d;
      main_pll_q <= main_pll_d;
      main_ref_q <= main_ref_d;
      gp_div_q   <= gp_div_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main clock PLL and the two system clock PLLs

  logic       main_tick, main_lvl;
  logic [1:0] sc_lvl;

  scg_dpll #(.GAIN(`SCG_DPLL_GAIN)) u_main_pll (
    .clk      (clk),
    .nrst     (nrst),
    .ref_tick (ref_tick_q),
    .r_div    (main_ref_q[`SCG_REF_R_MSB:`SCG_REF_R_LSB]),
    .n_mul    (main_pll_q[`SCG_PLL_N_MSB:`SCG_PLL_N_LSB]),
    .v_div    (main_pll_q[`SCG_PLL_V_MSB:`SCG_PLL_V_LSB]),
    .vco_tick (main_tick),
    .out_lvl  (main_lvl)
  );

  for (genvar g = 0; g < 2; g++) begin : g_sc
    scg_dpll #(.GAIN(`SCG_DPLL_GAIN)) u_sc_pll (
      .clk      (clk),
      .nrst     (nrst),
      .ref_tick (ref_tick_q),
      .r_div    (sc_ref_q[g][`SCG_REF_R_MSB:`SCG_REF_R_LSB]),
      .n_mul    (sc_pll_q[g][`SCG_PLL_N_MSB:`SCG_PLL_N_LSB]),
      .v_div    (sc_pll_q[g][`SCG_PLL_V_MSB:`SCG_PLL_V_LSB]),
      .vco_tick (),
      .out_lvl  (sc_lvl[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Derived ticks and registered outputs

  scg_word_t  gcnt_q, gcnt_d;
  logic [15:0] ccnt_q, ccnt_d;
  logic       gp_tick_d, conv_q, conv_d, main_q;
  logic [1:0] sco_q, sco_d;
  scg_route_t route;

  always_comb begin
    gcnt_d    = gcnt_q;
    gp_tick_d = 1'b0;
    if (main_tick) begin
      gp_tick_d = (gcnt_q >= gp_div_q - 16'h0001);
      gcnt_d    = gp_tick_d ? '0 : gcnt_q + 16'h0001;
    end
    ccnt_d = ccnt_q;
    conv_d = 1'b0;
    if (ref_tick_q) begin
      conv_d = (ccnt_q >= 16'(CONV_DIV - 1));
      ccnt_d = conv_d ? '0 : ccnt_q + 16'h0001;
    end
    route = '0;
    for (int i = 0; i < 2; i++) begin
      route    = sc_ref_q[i][`SCG_REF_ROUTE_MSB:`SCG_REF_ROUTE_LSB];
      // Powersave and disable both hold the pin low
      sco_d[i] = sc_ref_q[i][`SCG_REF_EN_BIT] && !sc_ref_q[i][`SCG_REF_PS_BIT] &&
                 ((route == `SCG_ROUTE_REF) ? ref_lvl_q : sc_lvl[i]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gcnt_q    <= '0;
      gp_tick_q <= 1'b0;
      ccnt_q    <= '0;
      conv_q    <= 1'b0;
      main_q    <= 1'b0;
      sco_q     <= '0;
    end else begin
      gcnt_q    <= gcnt_d;
      gp_tick_q <= gp_tick_d;
      ccnt_q    <= ccnt_d;
      conv_q    <= conv_d;
      main_q    <= main_lvl;
      sco_q     <= sco_d;
    end
  end

  assign system_clock_output_one = sco_q[0];
  assign system_clock_output_two = sco_q[1];
  assign main_clock_out          = main_q;
  assign general_purpose_timer_tick           = gp_tick_q;
  assign converter_tick          = conv_q;

endmodule // scg_top

`default_nettype wire

// ==== bench/scg_host_model.sv ====
// Host model: sends serial control bus frames to the clock generator.
`timescale 1ns/1ps
`default_nettype none
module scg_host_model (
  // Clock
  input  wire logic clk,
  // Serial bus
  output logic      cbus_sclk,
  output logic      cbus_csn_n,
  output logic      cbus_cmd_data
);
  initial begin
    cbus_sclk     = 1'b0;
    cbus_csn_n    = 1'b1;
    cbus_cmd_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Address then data, MSB first; fewer than 24 bits cuts the frame short
  task automatic send(input logic [7:0] addr, input logic [15:0] data, input int nbits);
    logic [23:0] sr;
    sr = {addr, data};
    @(negedge clk);
    cbus_csn_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      cbus_cmd_data = sr[23-i];
      repeat (4) @(negedge clk);
      cbus_sclk = 1'b1;
      repeat (4) @(negedge clk);
      cbus_sclk = 1'b0;
    end
    // Released data line shows the inverse so a stale bit is never read
    cbus_csn_n    = 1'b1;
    cbus_cmd_data = ~cbus_cmd_data;
    repeat (4) @(negedge clk);
  endtask
endmodule // scg_host_model
`default_nettype wire

// ==== bench/scg_top_assertions.sv ====
// Checker: pin timing of the system clock generator.
`timescale 1ns/1ps
`default_nettype none
module scg_top_assertions #(
  parameter bit REDUCED = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Reference and bus select
  input wire logic osc_in,
  input wire logic ref_ext_select,
  input wire logic cbus_csn_n,
  // Clock outputs
  input wire logic system_clock_output_one,
  input wire logic system_clock_output_two,
  input wire logic main_clock_out,
  input wire logic general_purpose_timer_tick,
  input wire logic converter_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Reference history, cycle count, main clock stall count, first frame seen
  logic [6:0]  osc_q, osc_d;
  logic [15:0] cyc_q, cyc_d;
  logic [7:0]  stall_q, stall_d;
  logic        mck_q, mck_d, seen_q, seen_d, warm, steady;
  always_comb begin
    osc_d   = {osc_q[5:0], osc_in};
    cyc_d   = cyc_q + {15'h0000, cyc_q != 16'hffff};
    stall_d = (main_clock_out != mck_q) ? 8'h00 : stall_q + {7'h00, stall_q != 8'hff};
    mck_d   = main_clock_out;
    seen_d  = seen_q | ~cbus_csn_n;
    // Main loop gets time to settle before its rate is judged
    warm    = cyc_q > 16'h4e20;
    steady  = (osc_q[6:1] == 6'h00 || osc_q[6:1] == 6'h3f) && cyc_q > 16'h0008;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      {osc_q, cyc_q, stall_q, mck_q, seen_q} <= '0;
    else
      {osc_q, cyc_q, stall_q, mck_q, seen_q} <= {osc_d, cyc_d, stall_d, mck_d, seen_d};
  end
  ////////////////////////////////////////////////////////////
  property p_rst_quiet;
    $rose(nrst) |-> !(system_clock_output_one | system_clock_output_two | main_clock_out);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("clock pin active at reset release");
  property p_gp_pulse;
    general_purpose_timer_tick |=> !general_purpose_timer_tick [*4];
  endproperty
  a_gp_pulse: assert property (p_gp_pulse)
    else $error("timer tick too long or too close");
  property p_conv_gap;
    converter_tick |=> !converter_tick [*8];
  endproperty
  a_conv_gap: assert property (p_conv_gap)
    else $error("converter tick too long or too close");
  property p_main_rate;
    warm |-> stall_q < 8'hc8;
  endproperty
  a_main_rate: assert property (p_main_rate)
    else $error("main clock stalled");
  property p_sc1_follow;
    (!REDUCED && !seen_q && ref_ext_select && steady) |-> system_clock_output_one == osc_q[3];
  endproperty
  a_sc1_follow: assert property (p_sc1_follow)
    else $error("output one does not carry the reference");
  property p_sc2_follow;
    (!REDUCED && !seen_q && ref_ext_select && steady) |-> system_clock_output_two == osc_q[3];
  endproperty
  a_sc2_follow: assert property (p_sc2_follow)
    else $error("output two does not carry the reference");
  property p_reduced_off;
    (REDUCED && !seen_q) |-> !system_clock_output_one && !system_clock_output_two;
  endproperty
  a_reduced_off: assert property (p_reduced_off)
    else $error("reduced part drives a clock before enable");
  property p_sc1_width;
    $rose(system_clock_output_one) |=> system_clock_output_one;
  endproperty
  a_sc1_width: assert property (p_sc1_width)
    else $error("output one high for a single cycle");
endmodule // scg_top_assertions

bind scg_top scg_top_assertions #(.REDUCED(REDUCED)) scg_top_assertions_inst (
  .clk(clk), .nrst(nrst), .osc_in(osc_in), .ref_ext_select(ref_ext_select),
  .cbus_csn_n(cbus_csn_n), .system_clock_output_one(system_clock_output_one),
  .system_clock_output_two(system_clock_output_two), .main_clock_out(main_clock_out),
  .general_purpose_timer_tick(general_purpose_timer_tick), .converter_tick(converter_tick));
`default_nettype wire

// ==== bench/system_clock_generators_tb_top.sv ====
// Testbench: host frames on the serial bus, edge counts on the clock pins.
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module system_clock_generators_tb_top;
  import scg_pkg::*;
  // Stimulus
  logic       clk              = 1'b0;
  logic       nrst             = 1'b0;
  logic       osc_in           = 1'b0;
  logic       ref_ext_select   = 1'b1;
  logic       idle_mode        = 1'b0;
  logic       clock_param_load = 1'b0;
  scg_word_t  gp_div           = 16'h1800;
  logic       cbus_sclk, cbus_csn_n, cbus_cmd_data, quiet;
  // Index 1 is the reduced variant
  logic [1:0] sc1, sc2, mck, gpt, cvt;
  logic [5:0] prev             = 6'h00;
  logic [5:0] cur;
  int         e[6]             = '{0, 0, 0, 0, 0, 0};
  int         d[6];
  int         cyc              = 0;
  int         err_total        = 0;
  int         total_checks     = 0;

  always #2.5 clk = ~clk;
  always begin
    repeat (16) @(negedge clk);
    osc_in = ~osc_in;
  end

  for (genvar i = 0; i < 2; i++) begin : g_part
    scg_top #(.REDUCED(i == 1), .CONV_DIV(4)) scg_top_inst (
      .clk(clk), .nrst(nrst), .osc_in(osc_in), .ref_ext_select(ref_ext_select),
      .cbus_sclk(cbus_sclk), .cbus_csn_n(cbus_csn_n), .cbus_cmd_data(cbus_cmd_data),
      .idle_mode(idle_mode), .clock_param_load(clock_param_load),
      .clock_param_main_pll(`SCG_MAIN_PLL_RST), .clock_param_main_ref(`SCG_MAIN_REF_RST),
      .clock_param_gp_div(gp_div), .system_clock_output_one(sc1[i]),
      .system_clock_output_two(sc2[i]), .main_clock_out(mck[i]), .general_purpose_timer_tick(gpt[i]),
      .converter_tick(cvt[i]));
  end
  scg_host_model scg_host_model_inst (.clk(clk), .cbus_sclk(cbus_sclk),
    .cbus_csn_n(cbus_csn_n), .cbus_cmd_data(cbus_cmd_data));
  ////////////////////////////////////////////////////////////
  // Rising edges: output one, output two, reduced output one, main clock, converter, timer
  assign cur = {gpt[0], cvt[0], mck[0], sc1[1], sc2[0], sc1[0]};
  always @(posedge clk) begin
    prev <= cur;
    for (int k = 0; k < 6; k++)
      if (prev[k] === 1'b0 && cur[k] === 1'b1)
        e[k] <= e[k] + 1;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] in_rng(input int v, input int lo, input int hi);
    return {15'h0000, v >= lo && v <= hi};
  endfunction
  task automatic window(input int n);
    int b[6];
    b = e;
    repeat (n) @(negedge clk);
    foreach (d[k]) d[k] = e[k] - b[k];
  endtask
  // Bounded wait for a timer tick; quiet stays set while output two is low
  task automatic wait_tick(output logic q);
    q = 1'b1;
    for (int n = 0; n < 700; n++) begin
      @(negedge clk);
      if (gpt[0] === 1'b1)
        return;
      q = q && (sc2[0] === 1'b0);
    end
    q = 1'b0;
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    // External reference of 32-cycle period passes straight to the full part's pins; the reduced part stays low
    window(3200);
    check(in_rng(d[0], 99, 101), 16'h0001);
    check(in_rng(d[1], 99, 101), 16'h0001);
    check(d[2][15:0], 16'h0000);
    // Crystal reference; timer divider comes through the firmware port, never the bus
    ref_ext_select = 1'b0;
    gp_div = 16'h0040;
    clock_param_load = 1'b1;
    @(negedge clk);
    clock_param_load = 1'b0;
    // 96 kHz comparison; output one 1.536 MHz, output two 0.768 MHz
    scg_host_model_inst.send(`SCG_ADDR_SC1_REF, 16'h2040, 24);
    scg_host_model_inst.send(`SCG_ADDR_SC1_PLL, 16'h1020, 24);
    scg_host_model_inst.send(`SCG_ADDR_SC2_REF, 16'h2040, 24);
    scg_host_model_inst.send(`SCG_ADDR_SC2_PLL, 16'h4040, 24);
    repeat (30000) @(negedge clk);
    window(10000);
    check(in_rng(d[0], 73, 81), 16'h0001);
    check(in_rng(d[1], 36, 41), 16'h0001);
    check(in_rng(d[2], 73, 81), 16'h0001);
    // Main pin 12.288 MHz, converter at reference over 4, timer every 64 main ticks
    check(in_rng(d[3], 590, 640), 16'h0001);
    check(in_rng(d[4], 75, 79), 16'h0001);
    check(in_rng(d[5], 18, 20), 16'h0001);
    // Powersave output two only
    scg_host_model_inst.send(`SCG_ADDR_SC2_REF, 16'h3040, 24);
    window(2000);
    check(d[1][15:0], 16'h0000);
    check(in_rng(d[0], 14, 17), 16'h0001);
    // Output one routed to the crystal reference
    scg_host_model_inst.send(`SCG_ADDR_SC1_REF, 16'h6040, 24);
    window(2000);
    check(in_rng(d[0], 60, 63), 16'h0001);
    // Reserved address and a short frame leave the setting alone
    scg_host_model_inst.send(8'haf, 16'h1000, 24);
    scg_host_model_inst.send(`SCG_ADDR_SC1_REF, 16'h2040, 20);
    window(2000);
    check(in_rng(d[0], 60, 63), 16'h0001);
    // Low-activity state: the write waits for the next timer tick
    idle_mode = 1'b1;
    wait_tick(quiet);
    scg_host_model_inst.send(`SCG_ADDR_SC2_REF, 16'h6040, 24);
    wait_tick(quiet);
    check({15'h0000, quiet}, 16'h0001);
    window(300);
    check(in_rng(d[1], 6, 12), 16'h0001);
    conclude();
  end
endmodule // system_clock_generators_tb_top
`default_nettype wire
